//--- sim/parallel_port_pin_control_tb_top.sv
// Self-checking bench for the parallel port pin control block.
// Assumes the block is the only AXI4-Lite slave and pins see pull-ups.
`timescale 1ns/1ps

module parallel_port_pin_control_tb_top;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] awaddr = '0;
    logic [15:0] araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [6:0][7:0] pinIn, pinLevel;
    logic [6:0][7:0] extVal = '0;
    logic [6:0][7:0] extOe = '0;
    logic [6:1][7:0] pinOut, pinOe;
    logic [3:0][7:0] periphOut = '0;
    int badCount = 0;
    int totalChecks = 0;
    logic [7:0] pat;
    int p;

    always #5 sys_clk = ~sys_clk;

    parallel_port_pin_control parallel_port_pin_control_i (.sys_clk(sys_clk), .nrst(nrst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .pinLevel(pinLevel), .periphOut(periphOut));

    port_pins port_pins_i (.pinOut(pinOut), .pinOe(pinOe), .extVal(extVal), .extOe(extOe),
        .pinIn(pinIn));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Each task starts one edge late so a lowered ready never clashes with a new raise.
    task automatic wr(input logic [12:0] idx, input logic [7:0] val, input logic [1:0] er = 2'b00,
        input logic [3:0] st = 4'hf);
        @(posedge sys_clk);
        awaddr <= {1'b0, idx, 2'b00};
        wdata <= {24'h0, val};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Only the watchdog ends a wait for the answer.
        do begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        check({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask

    task automatic rdChk(input logic [12:0] idx, input logic [7:0] exp, input logic [1:0] er = 2'b00);
        @(posedge sys_clk);
        araddr <= {1'b0, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        check(rdata, {24'h0, exp});
        check({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
    endtask

    // Covers the one-cycle drive latency and the two-stage pin synchroniser.
    task automatic settle;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        badCount++;
        results();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rdChk(gpio_pkg::SEL_IDX[i], gpio_pkg::SEL_RST[i]);
            rdChk(gpio_pkg::DIR_IDX[i], gpio_pkg::DIR_RST[i]);
        end
        for (int i = 0; i < 6; i++) rdChk(gpio_pkg::LAT_IDX[i], gpio_pkg::LAT_RST[i]);
        rdChk(gpio_pkg::DRV_IDX, 8'h00);
        wr(13'h1f00, 8'h55, 2'b10);
        rdChk(13'h1f00, 8'h00, 2'b10);
        // A write with byte lane 0 disabled must leave the latch alone.
        wr(gpio_pkg::LAT_IDX[0], 8'h00, 2'b00, 4'h0);
        rdChk(gpio_pkg::LAT_IDX[0], gpio_pkg::LAT_RST[0]);
        for (int i = 0; i < 4; i++) begin
            p = gpio_pkg::GP_PORT[i];
            pat = 8'ha5 ^ 8'(i);
            wr(gpio_pkg::SEL_IDX[i], 8'h00);
            wr(gpio_pkg::DIR_IDX[i], 8'h00);
            wr(gpio_pkg::LAT_IDX[p - 1], pat);
            settle();
            check({24'h0, pinOut[p]}, {24'h0, pat});
            check({24'h0, pinOe[p]}, 32'h0000_00ff);
            rdChk(gpio_pkg::PIN_IDX[p], pat);
            wr(gpio_pkg::DIR_IDX[i], 8'hff);
            settle();
            check({24'h0, pinOe[p]}, {24'h0, ~pat});
            rdChk(gpio_pkg::PIN_IDX[p], pat);
        end
        wr(gpio_pkg::LAT_IDX[5], 8'hff);
        extVal[6] <= 8'h3c;
        extOe[6] <= 8'hff;
        extVal[0] <= 8'h96;
        extOe[0] <= 8'hff;
        settle();
        check({24'h0, pinOe[6]}, 32'h0);
        check({24'h0, pinLevel[6]}, 32'h0000_003c);
        rdChk(gpio_pkg::PIN_IDX[6], 8'h3c);
        rdChk(gpio_pkg::PIN_IDX[0], 8'h96);
        extOe <= '0;
        periphOut[0] <= 8'h3c;
        wr(gpio_pkg::DIR_IDX[0], 8'h00);
        wr(gpio_pkg::SEL_IDX[0], 8'h0f);
        wr(gpio_pkg::LAT_IDX[0], 8'h00);
        settle();
        check({24'h0, pinOut[1]}, 32'h0000_000c);
        rdChk(gpio_pkg::LAT_IDX[0], 8'h00);
        rdChk(gpio_pkg::PIN_IDX[1], 8'h0c);
        periphOut[0] <= 8'hc3;
        settle();
        check({24'h0, pinOut[1]}, 32'h0000_0003);
        wr(gpio_pkg::LAT_IDX[2], 8'h5a);
        wr(gpio_pkg::LAT_IDX[3], 8'h5a);
        wr(gpio_pkg::DRV_IDX, 8'hff);
        settle();
        rdChk(gpio_pkg::DRV_IDX, 8'hc0);
        check({24'h0, pinOe[4]}, 32'h0000_00ff);
        wr(gpio_pkg::DRV_IDX, 8'h80);
        settle();
        check({24'h0, pinOe[3]}, 32'h0000_00ff);
        check({24'h0, pinOe[4]}, 32'h0000_00a5);
        check({24'h0, pinOut[3]}, 32'h0000_005a);
        rdChk(gpio_pkg::PIN_IDX[4], 8'h5a);
        wr(gpio_pkg::PIN_IDX[3], 8'h00);
        settle();
        rdChk(gpio_pkg::PIN_IDX[3], 8'h5a);
        check({24'h0, pinOut[3]}, 32'h0000_005a);
        results();
    end
endmodule

//--- sim/port_pins.sv
// External circuit model for the port pins: pull-ups plus optional drivers.
// Assumes the bench supplies the external drive values and their enables.
`timescale 1ns/1ps

module port_pins (
    input wire logic [6:1][7:0] pinOut,
    input wire logic [6:1][7:0] pinOe,
    input wire logic [6:0][7:0] extVal,
    input wire logic [6:0][7:0] extOe,
    output logic [6:0][7:0] pinIn
);
    // Port 0 has no drivers in the device, so its enable is forced off.
    wire logic [6:0][7:0] devOe = {pinOe, 8'h00};
    wire logic [6:0][7:0] devOut = {pinOut, 8'h00};
    // Every pin has a pull-up, since open-drain pins need one to read high.
    // The device wins any clash; no scenario drives both sides on one pin.
    assign pinIn = (devOe & devOut) | (~devOe & extOe & extVal) | (~devOe & ~extOe);
endmodule

//--- src/gpio_pkg.sv
// Constants for the parallel port pin control block: register indices,
// reset values and bus answers. Assumes nothing beyond a SystemVerilog tool.
package gpio_pkg;

    // Register indices; the byte address on the bus is four times the index.
    // Entries run port 1, 2, 5, 6 for function select and direction.
    localparam logic [12:0] SEL_IDX [4] = '{13'h1fd0, 13'h1fc9, 13'h1ff1, 13'h1fd1};
    localparam logic [7:0] SEL_RST [4] = '{8'h00, 8'h80, 8'h80, 8'h00};
    localparam logic [12:0] DIR_IDX [4] = '{13'h1fd2, 13'h1fcb, 13'h1ff3, 13'h1fd3};
    localparam logic [7:0] DIR_RST [4] = '{8'hff, 8'h7f, 8'hff, 8'hff};

    // Output latches run port 1 to port 6.
    localparam logic [12:0] LAT_IDX [6] = '{13'h1fd4, 13'h1fcd, 13'h1ffc, 13'h1ffd, 13'h1ff5, 13'h1fd5};
    localparam logic [7:0] LAT_RST [6] = '{8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};

    // Pin level registers run port 0 to port 6.
    localparam logic [12:0] PIN_IDX [7] = '{13'h1fda, 13'h1fd6, 13'h1fcf, 13'h1ffe, 13'h1fff, 13'h1ff7, 13'h1fd7};

    localparam logic [12:0] DRV_IDX = 13'h1ff4;
    localparam logic [1:0] DRV_RST = 2'b00;
    localparam int DRV_P3_BIT = 7;
    localparam int DRV_P4_BIT = 6;

    // Port number served by each function select and direction entry.
    localparam int GP_PORT [4] = '{1, 2, 5, 6};

    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 14;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

//--- src/parallel_port_pin_control.sv
// Parallel port pin control: direction, function select, output latches,
// pin levels and the port 3/4 drive type, reached over AXI4-Lite.
// Assumes one 100 MHz clock and pads that resolve pinOut and pinOe.
// Functional notes
// R1: Direction bit 1 gives input or open-drain; 0 gives complementary output.
// R2: Open-drain output and input share one setting; the latch decides.
// R3: Software sets the latch bit before using a pin as input.
// R4: Function select 0 drives from the latch; 1 hands pin to peripheral.
// R5: Pin level reads return sampled pin state whatever the function select.
// R6: Each output latch holds the value driven on its port's pins.
// R7: Latch reaches the pin only while function select is 0.
// R8: Drive type bit 7 sets port 3, bit 6 port 4; 1 is complementary.
// R9: Complementary port 3 or 4 drives high when latch bit is one.
// R10: Writes to pin level registers are ignored.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps

module parallel_port_pin_control #(
    parameter int ADDR_W = 16
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [6:0][7:0] pinIn,
    output logic [6:1][7:0] pinOut,
    output logic [6:1][7:0] pinOe,
    output logic [6:0][7:0] pinLevel,
    input wire logic [3:0][7:0] periphOut
);

    // Open-drain bits drive only a low; complementary bits always drive.
    function automatic logic [7:0] driveEnable(input logic [7:0] data, input logic [7:0] openDrain);
        driveEnable = (openDrain & ~data) | ~openDrain;
    endfunction

    logic [3:0][7:0] sel_q;
    logic [3:0][7:0] dir_q;
    logic [5:0][7:0] lat_q;
    logic [1:0] drv_q;
    logic [6:0][7:0] level;

    logic [ADDR_W-1:0] awAddr_q;
    logic [7:0] wByte_q;
    logic wEn_q;
    logic awHeld_q;
    logic wHeld_q;
    logic awRdy_q;
    logic wRdy_q;
    logic bValid_q;
    logic [1:0] bResp_q;
    logic arRdy_q;
    logic rValid_q;
    logic [1:0] rResp_q;
    logic [7:0] rData_q;
    logic [6:1][7:0] pinOut_q;
    logic [6:1][7:0] pinOe_q;

    pin_sync #(
        .W(56)
    ) u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .d(pinIn),
        .q(level)
    );

    wire [12:0] awIdx = awAddr_q[gpio_pkg::IDX_MSB:gpio_pkg::IDX_LSB];
    wire [12:0] arIdx = araddr[gpio_pkg::IDX_MSB:gpio_pkg::IDX_LSB];

    wire [3:0] hitSelW;
    wire [3:0] hitDirW;
    wire [5:0] hitLatW;
    wire [6:0] hitPinW;
    wire [3:0] hitSelR;
    wire [3:0] hitDirR;
    wire [5:0] hitLatR;
    wire [6:0] hitPinR;
    wire hitDrvW = awIdx == gpio_pkg::DRV_IDX;
    wire hitDrvR = arIdx == gpio_pkg::DRV_IDX;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_dec4
            assign hitSelW[g] = awIdx == gpio_pkg::SEL_IDX[g];
            assign hitDirW[g] = awIdx == gpio_pkg::DIR_IDX[g];
            assign hitSelR[g] = arIdx == gpio_pkg::SEL_IDX[g];
            assign hitDirR[g] = arIdx == gpio_pkg::DIR_IDX[g];
        end
        for (g = 0; g < 6; g++) begin : g_dec6
            assign hitLatW[g] = awIdx == gpio_pkg::LAT_IDX[g];
            assign hitLatR[g] = arIdx == gpio_pkg::LAT_IDX[g];
        end
        for (g = 0; g < 7; g++) begin : g_dec7
            assign hitPinW[g] = awIdx == gpio_pkg::PIN_IDX[g];
            assign hitPinR[g] = arIdx == gpio_pkg::PIN_IDX[g];
        end
    endgenerate

    // Write channel: address and data are taken in either order, then the
    // register write and the response happen together.
    wire awTake = awvalid && awRdy_q;
    wire wTake = wvalid && wRdy_q;
    wire wrGo = awHeld_q && wHeld_q;
    wire wrStore = wrGo && wEn_q;
    wire wrMapped = |{hitSelW, hitDirW, hitLatW, hitPinW, hitDrvW};
    wire awHeldD = (awHeld_q || awTake) && !wrGo;
    wire wHeldD = (wHeld_q || wTake) && !wrGo;
    wire bValidD = wrGo || (bValid_q && !bready);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awRdy_q <= 1'b1;
            wRdy_q <= 1'b1;
            bValid_q <= 1'b0;
        end else begin
            awHeld_q <= awHeldD;
            wHeld_q <= wHeldD;
            awRdy_q <= !awHeldD && !bValidD;
            wRdy_q <= !wHeldD && !bValidD;
            bValid_q <= bValidD;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            awAddr_q <= '0;
            wByte_q <= 8'h00;
            wEn_q <= 1'b0;
            bResp_q <= gpio_pkg::RESP_OKAY;
        end else begin
            if (awTake) begin
                awAddr_q <= awaddr;
            end
            if (wTake) begin
                wByte_q <= wdata[7:0];
                wEn_q <= wstrb[0];
            end
            if (wrGo) begin
                bResp_q <= wrMapped ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
            end
        end
    end

    // R10: no pin storage
    // Register file. Pin level offsets are decoded but have no storage.
    generate
        for (g = 0; g < 4; g++) begin : g_cfg
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    sel_q[g] <= gpio_pkg::SEL_RST[g];
                    dir_q[g] <= gpio_pkg::DIR_RST[g];
                end else begin
                    if (wrStore && hitSelW[g]) begin
                        sel_q[g] <= wByte_q;
                    end
                    if (wrStore && hitDirW[g]) begin
                        dir_q[g] <= wByte_q;
                    end
                end
            end
        end
        for (g = 0; g < 6; g++) begin : g_lat
            // R6: latch holds data
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    lat_q[g] <= gpio_pkg::LAT_RST[g];
                end else if (wrStore && hitLatW[g]) begin
                    lat_q[g] <= wByte_q;
                end
            end
        end
    endgenerate

    // R8: drive type bits
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            drv_q <= gpio_pkg::DRV_RST;
        end else if (wrStore && hitDrvW) begin
            drv_q <= {wByte_q[gpio_pkg::DRV_P3_BIT], wByte_q[gpio_pkg::DRV_P4_BIT]};
        end
    end

    // Pin drive. Outputs are registered, so a register change shows on the
    // pads one cycle after the write completes.
    generate
        for (g = 0; g < 4; g++) begin : g_gp
            localparam int P = gpio_pkg::GP_PORT[g];
            // R4 R7: latch or peripheral
            wire [7:0] data = (sel_q[g] & periphOut[g]) | (~sel_q[g] & lat_q[P-1]);
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    pinOut_q[P] <= 8'hff;
                    pinOe_q[P] <= 8'h00;
                end else begin
                    pinOut_q[P] <= data;
                    // R1 R2: direction drive type
                    pinOe_q[P] <= driveEnable(data, dir_q[g]);
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pinOut_q[3] <= 8'hff;
            pinOut_q[4] <= 8'hff;
            pinOe_q[3] <= 8'h00;
            pinOe_q[4] <= 8'h00;
        end else begin
            pinOut_q[3] <= lat_q[2];
            pinOut_q[4] <= lat_q[3];
            // R8 R9: port drive mode
            pinOe_q[3] <= driveEnable(lat_q[2], {8{!drv_q[1]}});
            pinOe_q[4] <= driveEnable(lat_q[3], {8{!drv_q[0]}});
        end
    end

    // Read channel: data are taken from the registers and synchronised pins
    // in the cycle of the address handshake.
    logic [7:0] rdMux;
    logic rdHit;

    always_comb begin
        rdMux = 8'h00;
        rdHit = 1'b0;
        for (int k = 0; k < 4; k++) begin
            if (hitSelR[k]) begin
                rdMux = rdMux | sel_q[k];
                rdHit = 1'b1;
            end
            if (hitDirR[k]) begin
                rdMux = rdMux | dir_q[k];
                rdHit = 1'b1;
            end
        end
        for (int k = 0; k < 6; k++) begin
            if (hitLatR[k]) begin
                rdMux = rdMux | lat_q[k];
                rdHit = 1'b1;
            end
        end
        // R5: live pin level
        for (int k = 0; k < 7; k++) begin
            if (hitPinR[k]) begin
                rdMux = rdMux | level[k];
                rdHit = 1'b1;
            end
        end
        if (hitDrvR) begin
            rdMux[gpio_pkg::DRV_P3_BIT] = drv_q[1];
            rdMux[gpio_pkg::DRV_P4_BIT] = drv_q[0];
            rdHit = 1'b1;
        end
    end

    wire arTake = arvalid && arRdy_q;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            arRdy_q <= 1'b1;
            rValid_q <= 1'b0;
            rData_q <= 8'h00;
            rResp_q <= gpio_pkg::RESP_OKAY;
        end else if (arTake) begin
            arRdy_q <= 1'b0;
            rValid_q <= 1'b1;
            rData_q <= rdMux;
            rResp_q <= rdHit ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
        end else if (rValid_q && rready) begin
            arRdy_q <= 1'b1;
            rValid_q <= 1'b0;
        end
    end

    assign awready = awRdy_q;
    assign wready = wRdy_q;
    assign bvalid = bValid_q;
    assign bresp = bResp_q;
    assign arready = arRdy_q;
    assign rvalid = rValid_q;
    assign rresp = rResp_q;
    assign rdata = {24'h000000, rData_q};
    assign pinOut = pinOut_q;
    assign pinOe = pinOe_q;
    assign pinLevel = level;

    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (!nrst);

    sequence p1LatchWrite;
        wrStore && hitLatW[0] && sel_q[0] == 8'h00;
    endsequence

    sequence pinLevelWrite;
        wrGo && |hitPinW;
    endsequence

    sequence p3LevelRead;
        arTake && hitPinR[3];
    endsequence

    sequence p4HighHeld;
        (drv_q[0] && lat_q[3][1]) [*2];
    endsequence

    a_latch_to_pin: assert property ( // R6
        p1LatchWrite |-> ##2 pinOut_q[1] == $past(wByte_q, 2))
        else $error("Port 1 latch write did not reach the pins.");

    a_periph_owns_pin: assert property ( // R7
        sel_q[0][0] |=> pinOut_q[1][0] == $past(periphOut[0][0]))
        else $error("Peripheral signal does not control its pin.");

    a_standard_io_pin: assert property ( // R4
        !sel_q[3][0] |=> pinOut_q[6][0] == $past(lat_q[5][0]))
        else $error("Standard I/O pin does not follow its latch.");

    a_complementary_drive: assert property ( // R1
        (!sel_q[0][1] && !dir_q[0][1]) |=> pinOe_q[1][1])
        else $error("Complementary pin is not driven.");

    a_open_drain_io: assert property ( // R2
        (dir_q[1][2] && !sel_q[1][2]) |=> pinOe_q[2][2] == !$past(lat_q[1][2]))
        else $error("Open-drain pin drive does not follow the latch.");

    a_pin_write_ignored: assert property ( // R10
        pinLevelWrite |=> $stable(lat_q) && $stable(dir_q) && $stable(sel_q) && $stable(drv_q))
        else $error("Pin level write changed a register.");

    a_pin_level_read: assert property ( // R5
        p3LevelRead |=> rValid_q && rData_q == $past(level[3]))
        else $error("Pin level read does not return the pin state.");

    a_open_drain_port: assert property ( // R8
        !drv_q[1] |=> pinOe_q[3] == ~$past(lat_q[2]))
        else $error("Port 3 is not open-drain.");

    a_push_pull_high: assert property ( // R9
        p4HighHeld |-> pinOe_q[4][1] && pinOut_q[4][1])
        else $error("Complementary port 4 pin not driven high.");

    a_bresp_hold: assert property (
        bValid_q && !bready |=> bValid_q && $stable(bResp_q))
        else $error("Write response dropped before it was taken.");

endmodule

//--- src/pin_sync.sv
// Two-stage synchroniser for pin levels entering the core clock domain.
// Assumes the inputs are asynchronous and that only the second stage is used.
`timescale 1ns/1ps

module pin_sync #(
    parameter int W = 56
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule
